// file: inc/mit_pkg.sv
package mit_pkg;

  // ------------------------------------------------------------
  // instruction classes and timing
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    MIT_XOR_MEM_A    = 5'h00,
    MIT_XOR_IMM_DIR  = 5'h01,
    MIT_ACC_UNARY    = 5'h02,
    MIT_MOV_IND_A    = 5'h03,
    MIT_MOV_DIR_A    = 5'h04,
    MIT_MOV_REG_DIR  = 5'h05,
    MIT_MOV_DIR_DIR  = 5'h06,
    MIT_LOAD_PTR16   = 5'h07,
    MIT_CODE_MOVE    = 5'h08,
    MIT_EXT_READ8    = 5'h09,
    MIT_EXT_READ16   = 5'h0A,
    MIT_EXT_WRITE8   = 5'h0B,
    MIT_EXT_WRITE16  = 5'h0C,
    MIT_STACK_OP     = 5'h0D,
    MIT_XCH_REG      = 5'h0E,
    MIT_XCH_IND      = 5'h0F,
    MIT_XCH_DIR      = 5'h10,
    MIT_BIT_OP       = 5'h11,
    MIT_BIT_CARRY    = 5'h12,
    MIT_CARRY_OP     = 5'h13,
    MIT_MOV_A_REG    = 5'h14
  } mit_class_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [2:0] cycles;
    logic ext;
    logic wr;
    logic wide;
  } mit_timing_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mit_byte_t;

  // clocks of the core clock per machine cycle
  localparam logic [3:0] MIT_CLK_PER_MC = 4'h4;
  localparam logic [7:0] MIT_PORT_RESET = 8'hFF;
  localparam logic [2:0] MIT_EXT_ADDR_MC = 3'h1;

  typedef enum logic [1:0] {
    MIT_ST_IDLE = 2'b00,
    MIT_ST_RUN  = 2'b01,
    MIT_ST_EXT  = 2'b11
  } mit_state_t;

endpackage

// file: src/mit_timing_rom.sv
`timescale 1ns/100ps
`default_nettype none
module mit_timing_rom (
  input wire logic clk_i,
  input wire mit_pkg::mit_class_t class_i,
  output mit_pkg::mit_timing_t timing_o
);
  import mit_pkg::*;

  mit_timing_t timing_nxt;

  // constant table, read data registered
  always_comb begin
    timing_nxt = '{bytes: 2'h2, cycles: 3'h2, ext: 1'b0, wr: 1'b0, wide: 1'b0};
    case (class_i)
      MIT_XOR_MEM_A: timing_nxt = '{2'h2, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_XOR_IMM_DIR: timing_nxt = '{2'h3, 3'h3, 1'b0, 1'b0, 1'b0};
      MIT_ACC_UNARY: timing_nxt = '{2'h1, 3'h1, 1'b0, 1'b0, 1'b0};
      MIT_MOV_IND_A: timing_nxt = '{2'h1, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_MOV_DIR_A: timing_nxt = '{2'h2, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_MOV_REG_DIR: timing_nxt = '{2'h2, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_MOV_DIR_DIR: timing_nxt = '{2'h3, 3'h3, 1'b0, 1'b0, 1'b0};
      MIT_LOAD_PTR16: timing_nxt = '{2'h3, 3'h3, 1'b0, 1'b0, 1'b0};
      MIT_CODE_MOVE: timing_nxt = '{2'h1, 3'h4, 1'b0, 1'b0, 1'b0};
      MIT_EXT_READ8: timing_nxt = '{2'h1, 3'h4, 1'b1, 1'b0, 1'b0};
      MIT_EXT_READ16: timing_nxt = '{2'h1, 3'h4, 1'b1, 1'b0, 1'b1};
      MIT_EXT_WRITE8: timing_nxt = '{2'h1, 3'h4, 1'b1, 1'b1, 1'b0};
      MIT_EXT_WRITE16: timing_nxt = '{2'h1, 3'h4, 1'b1, 1'b1, 1'b1};
      MIT_STACK_OP: timing_nxt = '{2'h2, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_XCH_REG: timing_nxt = '{2'h1, 3'h1, 1'b0, 1'b0, 1'b0};
      MIT_XCH_IND: timing_nxt = '{2'h1, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_XCH_DIR: timing_nxt = '{2'h2, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_BIT_OP: timing_nxt = '{2'h2, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_BIT_CARRY: timing_nxt = '{2'h2, 3'h2, 1'b0, 1'b0, 1'b0};
      MIT_CARRY_OP: timing_nxt = '{2'h1, 3'h1, 1'b0, 1'b0, 1'b0};
      MIT_MOV_A_REG: timing_nxt = '{2'h1, 3'h1, 1'b0, 1'b0, 1'b0};
      default: timing_nxt = '{2'h1, 3'h1, 1'b0, 1'b0, 1'b0};
    endcase
  end

  always_ff @(posedge clk_i) begin
    timing_o <= timing_nxt;
  end
endmodule
`default_nettype wire

// file: src/mit_core_timing.sv
// Contract
// - xor memory into acc: 2 bytes, 2 cycles
// - xor immediate into direct: 3 bytes, 3 cycles
// - acc clear/cpl/swap/rotates: 1 byte, 1 cycle
// - acc to/from indirect: 1 byte, 2 cycles
// - acc direct/immediate moves: 2 bytes, 2 cycles
// - register/indirect direct moves: 2 bytes, 2 cycles
// - direct-direct, immediate-direct: 3 bytes, 3 cycles
// - load 16-bit pointer: 3 bytes, 3 cycles
// - code byte move: 1 byte, 4 cycles
// - external data move: 1 byte, 4 cycles
// - push/pop: 2 bytes, 2 cycles
// - exchanges: register 1/1, indirect 1/2, direct 2/2
// - bit clear/set/cpl/logic: 2 bytes, 2 cycles
// - bit to/from carry: 2 bytes, 2 cycles
// - low port open drain, written ones float
// - external access drives address/data strongly
`timescale 1ns/100ps
`default_nettype none
module mit_core_timing (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire mit_pkg::mit_class_t class_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic [7:0] ext_wdata_i,
  input wire logic [7:0] port_wr_i,
  input wire logic port_wr_en_i,
  input wire logic [7:0] low_port_address_bit_i,
  output logic [7:0] low_port_address_bit_o,
  output logic [7:0] low_port_address_bit_oe_o,
  output logic [7:0] port_pins_o,
  output logic ready_o,
  output logic done_o,
  output logic [1:0] length_o,
  output logic [7:0] high_addr_o,
  output logic addr_latch_o,
  output logic rd_strobe_n_o,
  output logic wr_strobe_n_o,
  output mit_pkg::mit_byte_t rdata_o
);
  import mit_pkg::*;

  // ------------------------------------------------------------
  // timing table
  // ------------------------------------------------------------
  mit_timing_t tim;
  mit_class_t class_r, class_nxt;

  mit_timing_rom u_rom (
    .clk_i(clk_i),
    .class_i(class_i),
    .timing_o(tim)
  );

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  logic [7:0] pin_s1_r, pin_s2_r;

  // two stages since the pins are asynchronous to the core
  always_ff @(posedge clk_i) begin
    pin_s1_r <= low_port_address_bit_i;
    pin_s2_r <= pin_s1_r;
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  mit_state_t state_r, state_nxt;
  logic [2:0] mc_r, mc_nxt;
  logic [3:0] clk_r, clk_nxt;
  logic load_r, load_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic [1:0] len_r, len_nxt;
  mit_timing_t cur_r, cur_nxt;

  function automatic logic last_clk(input logic [3:0] c);
    return c == MIT_CLK_PER_MC - 4'h1;
  endfunction

  // one-cycle wait after issue lets the table register settle
  always_comb begin
    state_nxt = state_r;
    mc_nxt = mc_r;
    clk_nxt = clk_r;
    load_nxt = 1'b0;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    len_nxt = len_r;
    cur_nxt = cur_r;
    class_nxt = class_r;
    case (state_r)
      MIT_ST_IDLE: begin
        if (issue_i && ready_r) begin
          ready_nxt = 1'b0;
          load_nxt = 1'b1;
          class_nxt = class_i;
          addr_nxt = ext_addr_i;
          wdata_nxt = ext_wdata_i;
          state_nxt = MIT_ST_RUN;
        end
      end
      MIT_ST_RUN: begin
        if (load_r) begin
          cur_nxt = tim;
          len_nxt = tim.bytes;
          mc_nxt = 3'h0;
          clk_nxt = 4'h0;
          if (tim.ext) begin
            state_nxt = MIT_ST_EXT;
          end
        end else begin
          clk_nxt = clk_r + 4'h1;
          if (last_clk(clk_r)) begin
            clk_nxt = 4'h0;
            mc_nxt = mc_r + 3'h1;
            if (mc_r + 3'h1 == cur_r.cycles) begin
              done_nxt = 1'b1;
              ready_nxt = 1'b1;
              state_nxt = MIT_ST_IDLE;
            end
          end
        end
      end
      MIT_ST_EXT: begin
        clk_nxt = clk_r + 4'h1;
        if (last_clk(clk_r)) begin
          clk_nxt = 4'h0;
          mc_nxt = mc_r + 3'h1;
          if (mc_r + 3'h1 == cur_r.cycles) begin
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
            state_nxt = MIT_ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = MIT_ST_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= MIT_ST_IDLE;
      mc_r <= 3'h0;
      clk_r <= 4'h0;
      load_r <= 1'b0;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      len_r <= 2'h0;
      cur_r <= '0;
      class_r <= MIT_ACC_UNARY;
    end else begin
      state_r <= state_nxt;
      mc_r <= mc_nxt;
      clk_r <= clk_nxt;
      load_r <= load_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      len_r <= len_nxt;
      cur_r <= cur_nxt;
      class_r <= class_nxt;
    end
  end

  // ------------------------------------------------------------
  // low port and external bus
  // ------------------------------------------------------------
  logic [7:0] latch_r, latch_nxt;
  logic [7:0] po_r, po_nxt;
  logic [7:0] poe_r, poe_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic ale_r, ale_nxt;
  logic rdn_r, rdn_nxt;
  logic wrn_r, wrn_nxt;
  mit_byte_t rd_r, rd_nxt;
  logic ext_addr_ph, ext_data_ph;

  assign ext_addr_ph = (state_r == MIT_ST_EXT) && (mc_r < MIT_EXT_ADDR_MC);
  assign ext_data_ph = (state_r == MIT_ST_EXT) && (mc_r >= MIT_EXT_ADDR_MC);

  // port latch zeros pull low; ones release the pin
  always_comb begin
    latch_nxt = port_wr_en_i ? port_wr_i : latch_r;
    po_nxt = 8'h00;
    poe_nxt = ~latch_r;
    hi_nxt = hi_r;
    ale_nxt = 1'b0;
    rdn_nxt = 1'b1;
    wrn_nxt = 1'b1;
    rd_nxt = '{valid: 1'b0, data: rd_r.data};
    if (ext_addr_ph) begin
      po_nxt = addr_r[7:0];
      poe_nxt = 8'hFF;
      ale_nxt = 1'b1;
      hi_nxt = cur_r.wide ? addr_r[15:8] : 8'h00;
    end else if (ext_data_ph) begin
      if (cur_r.wr) begin
        po_nxt = wdata_r;
        poe_nxt = 8'hFF;
        wrn_nxt = 1'b0;
      end else begin
        poe_nxt = 8'h00;
        rdn_nxt = 1'b0;
        if (done_nxt) begin
          rd_nxt = '{valid: 1'b1, data: pin_s2_r};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_r <= MIT_PORT_RESET;
      po_r <= 8'h00;
      poe_r <= 8'h00;
      hi_r <= 8'h00;
      ale_r <= 1'b0;
      rdn_r <= 1'b1;
      wrn_r <= 1'b1;
      rd_r <= '0;
    end else begin
      latch_r <= latch_nxt;
      po_r <= po_nxt;
      poe_r <= poe_nxt;
      hi_r <= hi_nxt;
      ale_r <= ale_nxt;
      rdn_r <= rdn_nxt;
      wrn_r <= wrn_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    port_pins_o <= pin_s2_r;
  end

  assign low_port_address_bit_o = po_r;
  assign low_port_address_bit_oe_o = poe_r;
  assign ready_o = ready_r;
  assign done_o = done_r;
  assign length_o = len_r;
  assign high_addr_o = hi_r;
  assign addr_latch_o = ale_r;
  assign rd_strobe_n_o = rdn_r;
  assign wr_strobe_n_o = wrn_r;
  assign rdata_o = rd_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_issue;
    issue_i && ready_r && state_r == MIT_ST_IDLE;
  endsequence

  // eight quiet cycles; long waits are chained from short runs to keep the unroll small
  sequence s_quiet8;
    !done_r [*8];
  endsequence

  a_xor_mem_len: assert property (@(posedge clk_i) disable iff (rst_i)
    s_issue and class_i == MIT_XOR_MEM_A |-> ##10 done_r && len_r == 2'h2)
    else $error("xor memory timing wrong");
  a_xor_imm_len: assert property (@(posedge clk_i) disable iff (rst_i)
    s_issue and class_i == MIT_XOR_IMM_DIR |-> ##14 done_r && len_r == 2'h3)
    else $error("xor immediate timing wrong");
  a_unary_one: assert property (@(posedge clk_i) disable iff (rst_i)
    s_issue and class_i == MIT_ACC_UNARY |-> ##6 done_r && len_r == 2'h1)
    else $error("unary timing wrong");
  a_code_four: assert property (@(posedge clk_i) disable iff (rst_i)
    s_issue and class_i == MIT_CODE_MOVE |=> s_quiet8 ##1 s_quiet8 ##1 !done_r ##1 done_r)
    else $error("code move timing wrong");
  a_ext_four: assert property (@(posedge clk_i) disable iff (rst_i)
    s_issue and class_i == MIT_EXT_READ8 |-> ##18 done_r && len_r == 2'h1)
    else $error("external move timing wrong");
  a_ptr_three: assert property (@(posedge clk_i) disable iff (rst_i)
    s_issue and class_i == MIT_LOAD_PTR16 |-> ##14 done_r && len_r == 2'h3)
    else $error("pointer load timing wrong");
  a_no_overlap: assert property (@(posedge clk_i) disable iff (rst_i)
    !ready_r |=> ready_r == done_r)
    else $error("instruction overlap");
  a_port_float: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r != MIT_ST_EXT && $past(state_r) != MIT_ST_EXT && $stable(latch_r)
      |=> poe_r == ~$past(latch_r) && po_r == 8'h00)
    else $error("port open drain wrong");
  a_ext_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    ale_r |-> poe_r == 8'hFF && po_r == addr_r[7:0])
    else $error("address not driven");
  a_xch_len: assert property (@(posedge clk_i) disable iff (rst_i)
    done_r && class_r == MIT_XCH_IND |-> len_r == 2'h1)
    else $error("exchange length wrong");
endmodule
`default_nettype wire

// file: dv/mit_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// external data memory on the shared bus
// ----------------------------------------
module mit_ext_mem (
  input wire logic clk_i,
  input wire logic addr_latch_i,
  input wire logic [7:0] high_addr_i,
  input wire logic [7:0] bus_i,
  input wire logic rd_strobe_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic rd_slow_i,
  output logic [7:0] bus_o,
  output logic bus_oe_o
);
  logic [7:0] mem_r [0:65535];
  logic [15:0] addr_r = 16'h0000;
  int rd_cnt_r = 0;
  // address is taken off the bus while the latch phase stands
  always_ff @(posedge clk_i) begin
    if (addr_latch_i) begin
      addr_r <= {high_addr_i, bus_i};
    end
    if (!wr_strobe_n_i) begin
      mem_r[addr_r] <= bus_i;
    end
    rd_cnt_r <= rd_strobe_n_i ? 0 : rd_cnt_r + 1;
  end
  // slow mode drives late, so a core sampling too early reads the float pattern
  assign bus_oe_o = !rd_strobe_n_i && (rd_cnt_r >= (rd_slow_i ? 6 : 0));
  assign bus_o = mem_r[addr_r];
endmodule
`default_nettype wire

// file: dv/mit_core_timing_bench.sv
`timescale 1ns/100ps
`default_nettype none
module mit_core_timing_bench;
  import mit_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic issue_i = 1'b0;
  mit_class_t class_i = MIT_XOR_MEM_A;
  logic [15:0] ext_addr_i = 16'h0000;
  logic [7:0] ext_wdata_i = 8'h00;
  logic [7:0] port_wr_i = 8'hFF;
  logic port_wr_en_i = 1'b0;
  logic ext_hold = 1'b0;
  logic rd_slow = 1'b0;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] float_v = 8'h00;
  logic [7:0] pins, dout, oe, port_pins_o, high_addr_o, mem_d;
  logic ready_o, done_o, addr_latch_o, rd_strobe_n_o, wr_strobe_n_o, mem_oe;
  logic [1:0] length_o;
  mit_byte_t rdata_o;
  int error_cnt = 0;
  int samples_checked = 0;
  localparam logic [1:0] EXP_B [21] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
  localparam logic [2:0] EXP_C [21] = '{3'h2, 3'h3, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3,
    3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h2, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1};

  always #4 clk_i = ~clk_i;
  // a floating pin shows a shifting pattern, never a settled guess
  always_ff @(posedge clk_i) float_v <= {float_v[6:0], ~float_v[7]};
  always_comb pins = (oe & dout) | (~oe & (mem_oe ? mem_d : (ext_hold ? ext_val : float_v)));

  mit_core_timing u_mit_core_timing (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue_i),
    .class_i(class_i), .ext_addr_i(ext_addr_i), .ext_wdata_i(ext_wdata_i),
    .port_wr_i(port_wr_i), .port_wr_en_i(port_wr_en_i), .low_port_address_bit_i(pins),
    .low_port_address_bit_o(dout), .low_port_address_bit_oe_o(oe),
    .port_pins_o(port_pins_o), .ready_o(ready_o), .done_o(done_o), .length_o(length_o),
    .high_addr_o(high_addr_o), .addr_latch_o(addr_latch_o), .rd_strobe_n_o(rd_strobe_n_o),
    .wr_strobe_n_o(wr_strobe_n_o), .rdata_o(rdata_o));
  mit_ext_mem u_mit_ext_mem (.clk_i(clk_i), .addr_latch_i(addr_latch_o),
    .high_addr_i(high_addr_o), .bus_i(pins), .rd_strobe_n_i(rd_strobe_n_o),
    .wr_strobe_n_i(wr_strobe_n_o), .rd_slow_i(rd_slow), .bus_o(mem_d), .bus_oe_o(mem_oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one instruction, entered at a falling edge and left in its done cycle
  task automatic run_op(input mit_class_t cls, input logic [15:0] addr, input logic [7:0] wd,
      input logic [1:0] eb, input logic [2:0] ec, input logic rd_chk, input logic [7:0] rd_exp);
    int n;
    logic seen_addr;
    class_i = cls;
    ext_addr_i = addr;
    ext_wdata_i = wd;
    issue_i = 1'b1;
    @(negedge clk_i);
    issue_i = 1'b0;
    n = 1;
    seen_addr = 1'b0;
    while (done_o !== 1'b1 && n < 40) begin
      check(ready_o, 1'b0, "busy ready");
      if (addr_latch_o === 1'b1 && !seen_addr) begin
        seen_addr = 1'b1;
        check(oe, 8'hFF, "addr drive");
        check(dout, addr[7:0], "low addr");
        check(high_addr_o, (cls inside {MIT_EXT_READ16, MIT_EXT_WRITE16}) ? addr[15:8] : 8'h00,
          "high addr");
      end
      if (wr_strobe_n_o === 1'b0) check(dout & oe, wd, "write data");
      if (rd_strobe_n_o === 1'b0) check(oe, 8'h00, "read release");
      @(negedge clk_i);
      n++;
    end
    check(n, 2 + 4 * ec, "cycles");
    check(length_o, eb, "bytes");
    if (rd_chk) check(rdata_o, {1'b1, rd_exp}, "read data");
  endtask

  task automatic t_table();
    for (int i = 0; i < 21; i++) begin
      run_op(mit_class_t'(i), 16'h12A5, 8'h3C, EXP_B[i], EXP_C[i], 1'b0, 8'h00);
    end
    $display("test table done");
  endtask

  task automatic t_ext();
    run_op(MIT_EXT_WRITE8, 16'h003C, 8'hA5, 2'h1, 3'h4, 1'b0, 8'h00);
    run_op(MIT_EXT_WRITE16, 16'h7E81, 8'h5A, 2'h1, 3'h4, 1'b0, 8'h00);
    run_op(MIT_EXT_READ8, 16'h003C, 8'h00, 2'h1, 3'h4, 1'b1, 8'hA5);
    rd_slow = 1'b1;
    run_op(MIT_EXT_READ16, 16'h7E81, 8'h00, 2'h1, 3'h4, 1'b1, 8'h5A);
    rd_slow = 1'b0;
    $display("test ext done");
  endtask

  // latched ones float and read back what the outside world holds
  task automatic t_port();
    port_wr_i = 8'h5A;
    port_wr_en_i = 1'b1;
    @(negedge clk_i);
    port_wr_en_i = 1'b0;
    ext_hold = 1'b1;
    ext_val = 8'hF0;
    repeat (5) @(negedge clk_i);
    check(oe, 8'hA5, "open drain enables");
    check(dout & oe, 8'h00, "driven zeros");
    check(port_pins_o, 8'h50, "pin input");
    port_wr_i = 8'hFF;
    port_wr_en_i = 1'b1;
    @(negedge clk_i);
    port_wr_en_i = 1'b0;
    ext_hold = 1'b0;
    repeat (2) @(negedge clk_i);
    check(oe, 8'h00, "all float");
    $display("test port done");
  endtask

  // an issue during a busy instruction is dropped, a reset mid-run aborts
  task automatic t_refuse();
    class_i = MIT_CODE_MOVE;
    issue_i = 1'b1;
    @(negedge clk_i);
    issue_i = 1'b0;
    class_i = MIT_XCH_REG;
    repeat (3) @(negedge clk_i);
    issue_i = 1'b1;
    @(negedge clk_i);
    issue_i = 1'b0;
    repeat (13) @(negedge clk_i);
    check(done_o, 1'b1, "done after four");
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      check(done_o, 1'b0, "refused issue");
    end
    class_i = MIT_EXT_READ16;
    issue_i = 1'b1;
    @(negedge clk_i);
    issue_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 20; i++) begin
      check({ready_o, done_o, addr_latch_o, rd_strobe_n_o}, 4'h9, "after reset");
      @(negedge clk_i);
    end
    $display("test refuse done");
  endtask

  initial begin
    #100000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    check({ready_o, done_o, wr_strobe_n_o, rd_strobe_n_o, addr_latch_o}, 5'h16, "reset");
    check(oe, 8'h00, "reset float");
    t_table();
    t_ext();
    t_port();
    t_refuse();
    summarize();
  end
endmodule
`default_nettype wire
